// ### src/hv_meas_pkg.sv
// package for the high-voltage measurement path control
// assumes a single 100 MHz clock domain and synchronous active-high reset
package hv_meas_pkg;

  // --------------------------------------------------------------------------
  // operating modes
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    mode_init,
    mode_normal,
    mode_stop,
    mode_sleep,
    mode_restart,
    mode_fail_safe
  } op_mode_type;

  // --------------------------------------------------------------------------
  // fail/gpio pin configuration codes
  // --------------------------------------------------------------------------
  localparam int        gpio_cfg_width = 3;
  localparam logic [2:0] gpio_cfg_off  = 3'h4;
  localparam logic [2:0] gpio_cfg_fo   = 3'h0;
  localparam logic [2:0] gpio_cfg_wake = 3'h5;

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic       meas_enable_rst = 1'b0;
  localparam logic [1:0] pull_cfg_rst    = 2'h0;
  localparam logic [2:0] gpio_cfg_rst    = gpio_cfg_off;

  // pin-side control group
  typedef struct packed {
    logic       measure_route_switch;
    logic [1:0] sense_pull;
    logic       fail_gpio_pull;
    logic       sense_gate_open;
    logic       fail_gpio_gate_open;
    logic       fail_output_drive;
    logic       gpio_func_enable;
  } pin_ctrl_type;

  // wake status-update and wake-source permission group
  typedef struct packed {
    logic wake_status_0_update;
    logic wake_status_1_update;
    logic wake_level_status_update;
    logic sense_wake_active;
    logic gpio_wake_active;
  } wake_ctrl_type;

endpackage

// ### src/hv_meas_switch.sv
// combinational routing-switch decision
// assumes mode and enable come from registers in the same clock domain
module hv_meas_switch (
  input  wire logic                    voltage_measure_enable,
  input  hv_meas_pkg::op_mode_type     op_mode,
  output logic                         close_switch
);

  // --------------------------------------------------------------------------
  // switch closes only in normal mode with measurement enabled
  // --------------------------------------------------------------------------
  always_comb begin
    close_switch = voltage_measure_enable &&
                   (op_mode == hv_meas_pkg::mode_normal);
  end

endmodule

// ### src/hv_voltage_measure_path_ctrl.sv
// control of the high-voltage measurement path between sense input and fail/gpio pin
// assumes configuration writes arrive as one-cycle strobes with data, mode from the mode fsm
//
// Behaviour
// - After reset measurement is off, the switch is open and both pins keep their usual roles.
// - With measurement enabled in normal mode the switch joins the sense input to the pin.
// - In any mode other than normal the switch stays open whatever the enable says.
// - Leaving normal mode keeps the enable so the switch closes again on return.
// - While enabled, pulls on both pins are off and both internal pin signals are gated.
// - While enabled, pull, wake source and gpio writes are stored but have no pin effect.
// - While enabled, both wake status registers and the level status are not updated.
// - A sleep command with only pin wake sources while enabled faults and goes to restart.
// - While enabled, fail output, its test, all gpio functions and pin wake are off.
// - A gpio configuration write while enabled sets the command fault flag.
// - Enabling with the pin not off is refused and sets the command fault flag.
// - Wake enable bits stay writable while enabled but are ignored for detection.
// - Entering fail-safe with measurement enabled keeps the setting and opens the switch.
// - Entering fail-safe with measurement off makes the sense input a wake source.
module hv_voltage_measure_path_ctrl (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  hv_meas_pkg::op_mode_type   op_mode,
  input  wire logic                  meas_write,
  input  wire logic                  meas_write_data,
  input  wire logic                  pull_write,
  input  wire logic [1:0]            pull_write_data,
  input  wire logic                  wake_src_write,
  input  wire logic                  wake_src_write_data,
  input  wire logic                  gpio_write,
  input  wire logic [2:0]            gpio_write_data,
  input  wire logic                  fail_output_request,
  input  wire logic                  fail_output_test,
  input  wire logic                  sleep_command,
  input  wire logic                  other_wake_source,
  output logic                       voltage_measure_enable,
  output logic                       measure_route_switch,
  output hv_meas_pkg::pin_ctrl_type  pin_ctrl,
  output hv_meas_pkg::wake_ctrl_type wake_ctrl,
  output logic [1:0]                 wake_pull_config,
  output logic                       sense_wake_enable,
  output logic [2:0]                 gpio_config,
  output logic                       command_fault,
  output logic                       restart_request
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  // configuration group
  logic                       next_enable;
  logic [1:0]                 next_pull;
  logic                       next_wake_en;
  logic [2:0]                 next_gpio;
  logic                       enable_refused;
  // event group
  logic                       next_fault;
  logic                       next_restart;
  logic                       pin_wake_only;
  // mode tracking group
  hv_meas_pkg::op_mode_type   mode_prev;
  hv_meas_pkg::op_mode_type   next_mode_prev;
  logic                       failsafe_wake;
  logic                       next_failsafe_wake;
  // pin and wake permission group
  hv_meas_pkg::pin_ctrl_type  next_pin;
  hv_meas_pkg::wake_ctrl_type next_wake;
  logic                       next_switch;
  logic                       close_switch;

  // --------------------------------------------------------------------------
  // switch decision, computed from next values so the output has no lag
  // --------------------------------------------------------------------------
  hv_meas_switch u_switch (
    .voltage_measure_enable (next_enable),
    .op_mode                (op_mode),
    .close_switch           (close_switch)
  );

  // --------------------------------------------------------------------------
  // configuration
  // --------------------------------------------------------------------------
  // enable refused while the fail/gpio pin is not off, old gpio setting decides
  assign enable_refused = meas_write && meas_write_data &&
                          (gpio_config != hv_meas_pkg::gpio_cfg_off);

  // configuration next values, writes stored even while measuring
  always_comb begin
    next_enable  = voltage_measure_enable; // kept across modes
    next_pull    = wake_pull_config;
    next_wake_en = sense_wake_enable;
    next_gpio    = gpio_config;
    if (pull_write) begin
      next_pull = pull_write_data;
    end
    if (wake_src_write) begin
      next_wake_en = wake_src_write_data;
    end
    if (gpio_write) begin
      next_gpio = gpio_write_data;
    end
    if (meas_write && !enable_refused) begin
      next_enable = meas_write_data;
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      voltage_measure_enable <= hv_meas_pkg::meas_enable_rst;
      wake_pull_config       <= hv_meas_pkg::pull_cfg_rst;
      sense_wake_enable      <= 1'b0;
      gpio_config            <= hv_meas_pkg::gpio_cfg_rst;
    end else begin
      voltage_measure_enable <= next_enable;
      wake_pull_config       <= next_pull;
      sense_wake_enable      <= next_wake_en;
      gpio_config            <= next_gpio;
    end
  end

  // --------------------------------------------------------------------------
  // command fault and restart events
  // --------------------------------------------------------------------------
  // only pin wake sources armed, so sleep would leave no way back
  assign pin_wake_only = (sense_wake_enable ||
                          (gpio_config == hv_meas_pkg::gpio_cfg_wake)) && !other_wake_source;

  // one-cycle pulses, several causes may coincide
  always_comb begin
    next_fault   = 1'b0;
    next_restart = 1'b0;
    if (gpio_write && voltage_measure_enable) begin
      next_fault = 1'b1;
    end
    if (enable_refused) begin
      next_fault = 1'b1;
    end
    if (sleep_command && voltage_measure_enable && pin_wake_only) begin
      next_fault   = 1'b1;
      next_restart = 1'b1;
    end
  end

  // event registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      command_fault   <= 1'b0;
      restart_request <= 1'b0;
    end else begin
      command_fault   <= next_fault;
      restart_request <= next_restart;
    end
  end

  // --------------------------------------------------------------------------
  // mode tracking
  // --------------------------------------------------------------------------
  // fail-safe entry arms sense wake only when measurement is off, leaving disarms it
  always_comb begin
    next_mode_prev     = op_mode;
    next_failsafe_wake = failsafe_wake;
    if ((op_mode == hv_meas_pkg::mode_fail_safe) &&
        (mode_prev != hv_meas_pkg::mode_fail_safe)) begin
      next_failsafe_wake = !voltage_measure_enable;
    end else if (op_mode != hv_meas_pkg::mode_fail_safe) begin
      next_failsafe_wake = 1'b0;
    end
  end

  // mode tracking registers, init start so a fail-safe start still counts as entry
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_prev     <= hv_meas_pkg::mode_init;
      failsafe_wake <= 1'b0;
    end else begin
      mode_prev     <= next_mode_prev;
      failsafe_wake <= next_failsafe_wake;
    end
  end

  // --------------------------------------------------------------------------
  // pin and wake permissions
  // --------------------------------------------------------------------------
  // pin and wake permission next values
  always_comb begin
    next_switch                        = close_switch;
    next_pin.measure_route_switch      = close_switch;
    next_pin.sense_pull                = next_enable ? hv_meas_pkg::pull_cfg_rst
                                                     : next_pull;
    next_pin.fail_gpio_pull            = !next_enable;
    next_pin.sense_gate_open           = !next_enable;
    next_pin.fail_gpio_gate_open       = !next_enable;
    next_pin.fail_output_drive         = !next_enable &&
                                         (next_gpio == hv_meas_pkg::gpio_cfg_fo) &&
                                         (fail_output_request || fail_output_test);
    next_pin.gpio_func_enable          = !next_enable &&
                                         (next_gpio != hv_meas_pkg::gpio_cfg_off);
    next_wake.wake_status_0_update     = !next_enable;
    next_wake.wake_status_1_update     = !next_enable;
    next_wake.wake_level_status_update = !next_enable;
    next_wake.sense_wake_active        = !next_enable &&
                                         (next_wake_en || next_failsafe_wake);
    next_wake.gpio_wake_active         = !next_enable &&
                                         (next_gpio == hv_meas_pkg::gpio_cfg_wake);
  end

  // pin and wake permission registers, reset matches measurement off
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      measure_route_switch               <= 1'b0; // switch open
      pin_ctrl.measure_route_switch      <= 1'b0;
      pin_ctrl.sense_pull                <= hv_meas_pkg::pull_cfg_rst;
      pin_ctrl.fail_gpio_pull            <= !hv_meas_pkg::meas_enable_rst;
      pin_ctrl.sense_gate_open           <= !hv_meas_pkg::meas_enable_rst;
      pin_ctrl.fail_gpio_gate_open       <= !hv_meas_pkg::meas_enable_rst;
      pin_ctrl.fail_output_drive         <= 1'b0;
      pin_ctrl.gpio_func_enable          <= 1'b0;
      wake_ctrl.wake_status_0_update     <= !hv_meas_pkg::meas_enable_rst;
      wake_ctrl.wake_status_1_update     <= !hv_meas_pkg::meas_enable_rst;
      wake_ctrl.wake_level_status_update <= !hv_meas_pkg::meas_enable_rst;
      wake_ctrl.sense_wake_active        <= 1'b0;
      wake_ctrl.gpio_wake_active         <= 1'b0;
    end else begin
      measure_route_switch <= next_switch;
      pin_ctrl             <= next_pin;
      wake_ctrl            <= next_wake;
    end
  end

endmodule

// ### dv/hv_meas_chk.sv
// assertions on the measurement path control ports
// bound to the top module in the testbench top file
module hv_meas_chk (
  input wire logic                 clk_sys,
  input wire logic                 srst,
  input hv_meas_pkg::op_mode_type  op_mode,
  input wire logic                 meas_write,
  input wire logic                 meas_write_data,
  input wire logic                 gpio_write,
  input wire logic                 sleep_command,
  input wire logic                 other_wake_source,
  input wire logic                 voltage_measure_enable,
  input wire logic                 measure_route_switch,
  input hv_meas_pkg::pin_ctrl_type pin_ctrl,
  input hv_meas_pkg::wake_ctrl_type wake_ctrl,
  input wire logic                 sense_wake_enable,
  input wire logic [2:0]           gpio_config,
  input wire logic                 command_fault,
  input wire logic                 restart_request
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // enable request step
  sequence enable_req;
    meas_write && meas_write_data;
  endsequence
  rst_state_a: assert property ($past(srst) |-> !voltage_measure_enable &&
    !measure_route_switch && gpio_config == hv_meas_pkg::gpio_cfg_off) else $error("reset state");
  switch_mode_a: assert property (!$past(srst) |-> measure_route_switch ==
    (voltage_measure_enable && $past(op_mode) == hv_meas_pkg::mode_normal)) else $error("switch");
  enable_kept_a: assert property (voltage_measure_enable && !meas_write |=>
    voltage_measure_enable) else $error("enable lost");
  pins_gated_a: assert property (voltage_measure_enable |-> pin_ctrl.sense_pull == 2'h0 &&
    !pin_ctrl.fail_gpio_pull && !pin_ctrl.sense_gate_open && !pin_ctrl.fail_gpio_gate_open)
    else $error("pins not gated");
  status_frozen_a: assert property (voltage_measure_enable |-> !wake_ctrl.wake_status_0_update &&
    !wake_ctrl.wake_status_1_update && !wake_ctrl.wake_level_status_update) else $error("status");
  funcs_off_a: assert property (voltage_measure_enable |-> !pin_ctrl.fail_output_drive &&
    !pin_ctrl.gpio_func_enable && !wake_ctrl.sense_wake_active && !wake_ctrl.gpio_wake_active)
    else $error("pin functions on");
  gpio_fault_a: assert property (gpio_write && voltage_measure_enable |=> command_fault)
    else $error("no gpio fault");
  enable_refuse_a: assert property (enable_req ##0 (gpio_config != hv_meas_pkg::gpio_cfg_off &&
    !voltage_measure_enable) |=> command_fault && !voltage_measure_enable) else $error("refuse");
  sleep_fault_a: assert property (sleep_command && voltage_measure_enable && !other_wake_source &&
    (sense_wake_enable || gpio_config == hv_meas_pkg::gpio_cfg_wake) |=> command_fault &&
    restart_request) else $error("sleep fault");
endmodule

// ### dv/hv_adc_divider.sv
// model of the external divider feeding the adc input
// assumes the sense level is a plain level from the bench
module hv_adc_divider (
  input  wire logic measure_route_switch,
  input  wire logic hv_sense_level,
  output logic      adc_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // divider pulls the adc node to ground while the switch is open
  assign adc_level = measure_route_switch ? hv_sense_level : 1'b0;
endmodule

// ### dv/hv_voltage_measure_path_ctrl_tb.sv
// self-checking testbench for the measurement path control
// assumes package, design, divider model and checker are compiled first
module hv_voltage_measure_path_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, srst, meas_write, meas_write_data, pull_write, wake_src_write;
  logic        wake_src_write_data, gpio_write, fail_output_request, fail_output_test;
  logic        sleep_command, other_wake_source, voltage_measure_enable, measure_route_switch;
  logic        sense_wake_enable, command_fault, restart_request, hv_sense_level, adc_level;
  logic [1:0]  pull_write_data, wake_pull_config;
  logic [2:0]  gpio_write_data, gpio_config;
  int          fails, n_tests;
  hv_meas_pkg::op_mode_type   op_mode;
  hv_meas_pkg::pin_ctrl_type  pin_ctrl;
  hv_meas_pkg::wake_ctrl_type wake_ctrl;
  hv_voltage_measure_path_ctrl dut_u (.*);
  hv_adc_divider adc_u (.measure_route_switch(measure_route_switch),
    .hv_sense_level(hv_sense_level), .adc_level(adc_level));
  // ----------------------------------------------------------------
  // clock and tasks
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // compare one bit, count and report
  task automatic chk(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask
  // one-cycle strobe: 0 meas, 1 pull, 2 wake source, 3 gpio, 4 sleep
  task automatic wr(input int kind, input logic [2:0] d);
    @(posedge clk_sys);
    {meas_write, pull_write, wake_src_write} <= {kind == 0, kind == 1, kind == 2};
    {gpio_write, sleep_command} <= {kind == 3, kind == 4};
    {meas_write_data, wake_src_write_data, pull_write_data, gpio_write_data} <= {d[0], d[0], d[1:0], d};
    @(posedge clk_sys);
    {meas_write, pull_write, wake_src_write, gpio_write, sleep_command} <= 5'h00;
    #1;
  endtask
  // mode change, outputs settle one edge later
  task automatic mode(input hv_meas_pkg::op_mode_type m);
    @(posedge clk_sys);
    op_mode <= m;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {meas_write, pull_write, wake_src_write, gpio_write, sleep_command} = 5'h00;
    {meas_write_data, wake_src_write_data, pull_write_data, gpio_write_data} = 7'h00;
    {fail_output_request, fail_output_test, other_wake_source, hv_sense_level} = 4'hf;
    op_mode = hv_meas_pkg::mode_normal;
    fails = 0;
    n_tests = 0;
    srst = 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk(voltage_measure_enable | measure_route_switch, 1'b0, "reset outputs");
    chk(gpio_config === hv_meas_pkg::gpio_cfg_off, 1'b1, "reset gpio");
    wr(3, hv_meas_pkg::gpio_cfg_fo);
    wr(0, 3'h1);
    chk(command_fault & ~voltage_measure_enable, 1'b1, "enable not refused");
    chk(pin_ctrl.fail_output_drive, 1'b1, "fail output idle");
    @(posedge clk_sys) fail_output_request <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(pin_ctrl.fail_output_drive, 1'b1, "fail output test idle");
    wr(3, hv_meas_pkg::gpio_cfg_off);
    wr(0, 3'h1);
    chk(measure_route_switch & adc_level, 1'b1, "switch open");
    chk(pin_ctrl.measure_route_switch, 1'b1, "pin switch open");
    chk(pin_ctrl.sense_gate_open | pin_ctrl.fail_gpio_gate_open, 1'b0, "pins not gated");
    chk(pin_ctrl.fail_gpio_pull, 1'b0, "pin pull on");
    chk(pin_ctrl.fail_output_drive | pin_ctrl.gpio_func_enable, 1'b0, "fail output on");
    chk(wake_ctrl.wake_status_0_update, 1'b0, "status updating");
    chk(wake_ctrl.wake_status_1_update, 1'b0, "status 1 updating");
    chk(wake_ctrl.wake_level_status_update, 1'b0, "level updating");
    wr(1, 3'h3);
    chk(wake_pull_config === 2'h3 && pin_ctrl.sense_pull === 2'h0, 1'b1, "pull write");
    wr(2, 3'h1);
    chk(sense_wake_enable & ~wake_ctrl.sense_wake_active, 1'b1, "wake bit");
    wr(3, hv_meas_pkg::gpio_cfg_wake);
    chk(command_fault, 1'b1, "no gpio fault");
    @(posedge clk_sys) other_wake_source <= 1'b0;
    wr(4, 3'h0);
    chk(command_fault & restart_request, 1'b1, "sleep accepted");
    for (int m = 0; m < 6; m++) begin
      mode(hv_meas_pkg::op_mode_type'(m));
      chk(measure_route_switch, m == 1, "switch per mode");
      chk(pin_ctrl.measure_route_switch, m == 1, "pin switch per mode");
      chk(adc_level, m == 1, "adc level per mode");
      chk(voltage_measure_enable, 1'b1, "enable lost");
    end
    mode(hv_meas_pkg::mode_normal);
    chk(measure_route_switch, 1'b1, "no reclose");
    wr(2, 3'h0);
    wr(0, 3'h0);
    chk(wake_ctrl.wake_status_0_update & ~wake_ctrl.sense_wake_active, 1'b1, "pins back");
    chk(wake_ctrl.gpio_wake_active & pin_ctrl.gpio_func_enable, 1'b1, "gpio back");
    mode(hv_meas_pkg::mode_fail_safe);
    chk(wake_ctrl.sense_wake_active, 1'b1, "no fail-safe wake");
    tally_and_finish();
  end
endmodule
bind hv_voltage_measure_path_ctrl hv_meas_chk chk_u (
  .clk_sys                (clk_sys),
  .srst                   (srst),
  .op_mode                (op_mode),
  .meas_write             (meas_write),
  .meas_write_data        (meas_write_data),
  .gpio_write             (gpio_write),
  .sleep_command          (sleep_command),
  .other_wake_source      (other_wake_source),
  .voltage_measure_enable (voltage_measure_enable),
  .measure_route_switch   (measure_route_switch),
  .pin_ctrl               (pin_ctrl),
  .wake_ctrl              (wake_ctrl),
  .sense_wake_enable      (sense_wake_enable),
  .gpio_config            (gpio_config),
  .command_fault          (command_fault),
  .restart_request        (restart_request)
);
